// ===== tb/cpu_model.sv
// Execution pipeline stand-in: instruction ends, context bytes and counters.
`timescale 1ns/1ps
module cpu_model (
  input wire clk_i, sys_rst_i, vec_break_i, // clock, reset, vector start
  input wire push_valid_i, pop_valid_i, load_pc_i, // stack and entry pulses
  input wire [7:0] push_data_i, // pushed byte
  output reg instr_last_o, // last state of instruction
  output wire [23:0] pc_o, // suspended counter
  output wire [7:0] stat_o, // status word
  output reg [7:0] pushes_o, pops_o, gap_o, // counts, break to entry
  output reg [31:0] frame_o // last four bytes pushed
);
  reg [1:0] st_r;
  reg run_r;
  assign pc_o = 24'hC3A55A;
  assign stat_o = 8'h96;
  // Three-state instructions so the last state meets a poll only now and then.
  always @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      st_r <= 2'h0;
      instr_last_o <= 1'b0;
      pushes_o <= 8'h00;
      pops_o <= 8'h00;
      run_r <= 1'b0;
    end
    else
    begin
      st_r <= (st_r == 2'h2) ? 2'h0 : st_r + 2'h1;
      instr_last_o <= (st_r == 2'h1);
      if (push_valid_i)
        frame_o <= {push_data_i, frame_o[31:8]};
      pushes_o <= pushes_o + {7'h00, push_valid_i};
      pops_o <= pops_o + {7'h00, pop_valid_i};
      run_r <= vec_break_i | (run_r & ~load_pc_i);
      gap_o <= vec_break_i ? 8'h00 : run_r ? gap_o + 8'h01 : gap_o;
    end
endmodule // cpu_model

// ===== tb/irq_vector_asserts.sv
// Port-level assertions for the interrupt vectoring block.
`timescale 1ns/1ps
module irq_vector_asserts (
  input wire clk_i, sys_rst_i, instr_last_i, instr_blocking_i, // clock, pipeline
  input wire return_from_isr_i, subroutine_return_i, psel, penable, // returns, bus
  input wire pready, pslverr, vec_break_o, push_valid_o, pop_valid_o, // answers
  input wire load_pc_o, // routine entry
  input wire [23:0] load_addr_o // routine address
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  reg [2:0] np_r;
  // Pushes are counted per vector so the frame size shows at routine entry.
  always @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      np_r <= 3'h0;
    else if (vec_break_o)
      np_r <= 3'h0;
    else if (push_valid_o)
      np_r <= np_r + 3'h1;
  property p_cause; vec_break_o |-> $past(instr_last_i) && !$past(instr_blocking_i); endproperty
  a_cause: assert property (p_cause) else $error("vector off final state");
  property p_one; vec_break_o |=> !vec_break_o [*8]; endproperty
  a_one: assert property (p_one) else $error("second vector too soon");
  property p_load; vec_break_o |-> ##[6:20] load_pc_o; endproperty
  a_load: assert property (p_load) else $error("no entry after break");
  property p_frame; load_pc_o |-> np_r == 3'h2 || np_r == 3'h4; endproperty
  a_frame: assert property (p_frame) else $error("bad push count");
  property p_addr; load_pc_o |-> load_addr_o[2:0] == 3'h3; endproperty
  a_addr: assert property (p_addr) else $error("entry off spacing");
  property p_return_from_isr; return_from_isr_i |=> ##1 pop_valid_o ##1 pop_valid_o; endproperty
  a_return_from_isr: assert property (p_return_from_isr) else $error("return pops missing");
  property p_ret;
    subroutine_return_i |=> ##1 pop_valid_o ##1 pop_valid_o ##1 !pop_valid_o;
  endproperty
  a_ret: assert property (p_ret) else $error("plain return pops wrong");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; pslverr |-> pready && $past(psel); endproperty
  a_err: assert property (p_err) else $error("stray error");
  c_big: cover property (load_pc_o && np_r == 3'h4);
  c_ret: cover property (return_from_isr_i);
  c_err: cover property (pslverr);
endmodule // irq_vector_asserts
bind irq_vector_ctrl irq_vector_asserts chk (.clk_i, .sys_rst_i, .instr_last_i,
  .instr_blocking_i, .return_from_isr_i, .subroutine_return_i, .psel, .penable, .pready,
  .pslverr, .vec_break_o, .push_valid_o, .pop_valid_o, .load_pc_o, .load_addr_o);

// ===== tb/tb_top.sv
// Bench for the vectoring block: bus access, vectors, blocking, returns.
`timescale 1ns/1ps
`include "irq_vector_defines.vh"
module tb_top;
  logic clk_i, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, return_from_isr = 0, sret = 0;
  logic ext_irq0_n_i = 1, instr_blocking_i = 0, pready, pslverr, vec_break_o;
  logic push_valid_o, pop_valid_o, load_pc_o, irq_o, last, er, hit;
  logic [5:0] int_src_i = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, frame;
  logic [7:0] push_data_o, sw, pushes, pops, gap, g0, p0;
  logic [23:0] load_addr_o, pc, va;
  int failures = 0, compares = 0;
  irq_vector_ctrl DUT (.clk_i, .sys_rst_i, .int_src_i, .ext_irq0_n_i, .ext_irq1_n_i(1'b1),
    .instr_last_i(last), .instr_blocking_i, .return_from_isr_i(return_from_isr),
    .subroutine_return_i(sret), .pc_i(pc), .extended_status_word_i(sw), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vec_break_o, .push_valid_o,
    .push_data_o, .pop_valid_o, .load_pc_o, .load_addr_o, .irq_o);
  cpu_model cpu (.clk_i, .sys_rst_i, .vec_break_i(vec_break_o), .push_valid_i(push_valid_o),
    .pop_valid_i(pop_valid_o), .load_pc_i(load_pc_o), .push_data_i(push_data_o),
    .instr_last_o(last), .pc_o(pc), .stat_o(sw), .pushes_o(pushes), .pops_o(pops),
    .gap_o(gap), .frame_o(frame));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wvec(input int n);
    hit = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (load_pc_o === 1'b1)
      begin
        hit = 1;
        va = load_addr_o;
      end
    end
  endtask
  task ret(input logic full);
    p0 = pops;
    return_from_isr <= full;
    sret <= !full;
    @(posedge clk_i);
    return_from_isr <= 0;
    sret <= 0;
    repeat (8) @(posedge clk_i);
  endtask
  task tally_and_finish;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #20000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 0;
    apb(0, `IV_OFF_VECBASE, 0);
    chk("vecbase", 32'h00FF0003, rd);
    apb(0, 12'h020, 0);
    chk("unmapped", 1'b1, er);
    apb(1, `IV_OFF_ENABLE, 32'h000000FF);
    apb(1, `IV_OFF_MASK, 32'h00000001);
    int_src_i <= 6'h01;
    wvec(48);
    int_src_i <= 6'h02;
    chk("addr2", 24'hFF0013, va);
    chk("push2", 2, pushes);
    chk("frame2", 16'hA55A, frame[31:16]);
    chk("irq_set", 1'b1, irq_o);
    g0 = gap;
    apb(1, `IV_OFF_STATUS, 32'h00000001);
    apb(0, `IV_OFF_STATUS, 0);
    chk("irq_clr", 1'b0, irq_o);
    wvec(48);
    chk("held", 1'b0, hit);
    ret(1);
    chk("pop2", p0 + 8'h02, pops);
    wvec(48);
    int_src_i <= 6'h00;
    chk("addr3", 24'hFF001B, va);
    ret(1);
    apb(1, `IV_OFF_CTRL, 32'h00000007);
    int_src_i <= 6'h04;
    wvec(48);
    int_src_i <= 6'h00;
    chk("addr4", 24'hFF0023, va);
    chk("push4", 8, pushes);
    chk("frame4", 32'h96C3A55A, frame);
    chk("gap", g0 + 8'h06, gap);
    ret(0);
    chk("pop_ret", p0 + 8'h02, pops);
    ret(1);
    chk("pop4", p0 + 8'h04, pops);
    apb(1, `IV_OFF_STATUS, 32'h00000007);
    instr_blocking_i <= 1;
    ext_irq0_n_i <= 0;
    repeat (6) @(posedge clk_i);
    ext_irq0_n_i <= 1;
    repeat (12) @(posedge clk_i);
    instr_blocking_i <= 0;
    wvec(40);
    chk("dropped", 1'b0, hit);
    apb(0, `IV_OFF_STATUS, 0);
    chk("drop_bit", 1'b1, rd[2]);
    instr_blocking_i <= 1;
    ext_irq0_n_i <= 0;
    wvec(24);
    chk("blocked", 1'b0, hit);
    instr_blocking_i <= 0;
    wvec(48);
    ext_irq0_n_i <= 1;
    chk("addr0", 24'hFF0003, va);
    tally_and_finish;
  end
endmodule // tb_top

// ===== verilog/irq_vector_ctrl.v
// Interrupt sampling, blocking and vector-cycle sequencer with an APB register file.
//
// Operation
// - Sample and poll all sources once every four state times.
// - Base latency to first routine instruction is 16 state times.
// - Add one state for pin request, two for external code, four for external stack.
// - Withhold vector while equal or higher priority routine is in progress.
// - Withhold vector unless poll coincides with final instruction cycle.
// - After return or enable/priority write, at least two more instructions run first.
// - Only one prioritized request at a time starts a vector cycle.
// - Vector cycle breaks stream, pushes counter bytes, loads routine address.
// - Frame bit set pushes three counter bytes plus status; else two bytes.
// - Return from routine pops counter bytes and status when frame bit set.
// - Subroutine return pops only the lower two counter bytes.
// - Blocked level requests that clear are discarded, not retained.
// - Routine start addresses of consecutive sources are eight bytes apart.
`timescale 1ns/1ps
`include "irq_vector_defines.vh"
module irq_vector_ctrl (
  input wire clk_i, // 200 MHz core clock, one state time per cycle
  input wire sys_rst_i, // asynchronous reset, active high
  input wire [5:0] int_src_i, // internal request levels, same clock
  input wire ext_irq0_n_i, // external request pin 0, active low
  input wire ext_irq1_n_i, // external request pin 1, active low
  input wire instr_last_i, // current state is final state of instruction
  input wire instr_blocking_i, // instruction is return or enable/priority write
  input wire return_from_isr_i, // return-from-interrupt executes this state
  input wire subroutine_return_i, // plain subroutine return executes this state
  input wire [23:0] pc_i, // program counter of the suspended stream
  input wire [7:0] extended_status_word_i, // status word to save
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg vec_break_o, // pulse: break instruction stream
  output reg push_valid_o, // pulse per stack byte pushed
  output reg [7:0] push_data_o, // stack byte
  output reg pop_valid_o, // pulse per stack byte popped
  output reg load_pc_o, // pulse: load program counter
  output reg [23:0] load_addr_o, // routine start address
  output reg irq_o // level interrupt, unmasked status set
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_PUSH = 4'b0100;
  localparam ST_LOAD = 4'b1000;
  reg [3:0] state_r;
  reg [1:0] poll_cnt_r;
  reg [1:0] ext0_sync_r;
  reg [1:0] ext1_sync_r;
  reg [7:0] pend_r;
  reg [7:0] enable_r;
  reg [7:0] prio_r;
  reg [2:0] ctrl_r;
  reg [23:0] vec_base_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg [1:0] active_r;
  reg [2:0] sel_r;
  reg sel_hi_r;
  reg [3:0] wait_r;
  reg [2:0] bytes_r;
  reg [23:0] pc_save_r;
  reg [7:0] psw_save_r;
  reg [2:0] pop_r;
  reg block_next_r;
  wire [7:0] req;
  wire [7:0] eligible;
  wire apb_wr;
  wire apb_rd;
  wire poll_now;
  wire can_vector;
  wire [2:0] ev;
  wire [2:0] pick_hi;
  wire [2:0] pick_lo;
  wire any_hi;
  wire any_lo;
  wire [3:0] extra;
  wire [3:0] wait_states;
  genvar g;

  // Lowest index wins among equal-priority requests.
  function [3:0] first_set;
    input [7:0] v;
    integer k;
    begin
      first_set = 4'h0;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          first_set = {1'b1, k[2:0]};
    end
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign req = {int_src_i, ~ext1_sync_r[1], ~ext0_sync_r[1]};
  assign poll_now = (poll_cnt_r == 2'h3);
  generate
    for (g = 0; g < `IV_NUM_SRC; g = g + 1)
    begin : g_elig
      // A request is eligible only above every priority level in progress.
      assign eligible[g] = pend_r[g] && enable_r[g] &&
        (prio_r[g] ? !active_r[1] : (active_r == 2'b00));
    end
  endgenerate
  assign {any_hi, pick_hi} = first_set(eligible & prio_r);
  assign {any_lo, pick_lo} = first_set(eligible & ~prio_r);
  assign can_vector = (state_r == ST_IDLE) && poll_now && instr_last_i
    && !instr_blocking_i && !block_next_r && (any_hi || any_lo);
  // Wait after the poll so that request-to-first-instruction totals the latency.
  assign extra = (sel_r < 3'd2 ? 4'd`IV_ADD_EXT_PIN : 4'd0)
    + (ctrl_r[`IV_CTRL_EXT_EXEC_BIT] ? 4'd`IV_ADD_EXT_EXEC : 4'd0)
    + (ctrl_r[`IV_CTRL_EXT_STACK_BIT] ? 4'd`IV_ADD_EXT_STACK : 4'd0);
  assign wait_states = 4'd`IV_CTX_SWITCH_STATES - 4'd4 + extra;
  assign ev[`IV_ST_VECTOR_BIT] = can_vector;
  assign ev[`IV_ST_RETURN_BIT] = return_from_isr_i;
  assign ev[`IV_ST_DROP_BIT] = poll_now && |(pend_r & ~req) && !can_vector;

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ext0_sync_r <= 2'h3;
      ext1_sync_r <= 2'h3;
      poll_cnt_r <= 2'h0;
      pend_r <= 8'h00;
    end
    else
    begin
      ext0_sync_r <= {ext0_sync_r[0], ext_irq0_n_i};
      ext1_sync_r <= {ext1_sync_r[0], ext_irq1_n_i};
      poll_cnt_r <= poll_cnt_r + 2'h1;
      // Requests are resampled each poll, so a cleared level is lost.
      if (poll_now)
        pend_r <= req;
    end
  end

  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;
      sel_r <= 3'h0;
      sel_hi_r <= 1'b0;
      active_r <= 2'b00;
      wait_r <= 4'h0;
      bytes_r <= 3'h0;
      pc_save_r <= 24'h000000;
      psw_save_r <= 8'h00;
      pop_r <= 3'h0;
      block_next_r <= 1'b0;
      vec_break_o <= 1'b0;
      push_valid_o <= 1'b0;
      push_data_o <= 8'h00;
      pop_valid_o <= 1'b0;
      load_pc_o <= 1'b0;
      load_addr_o <= 24'h000000;
    end
    else
    begin
      vec_break_o <= 1'b0;
      push_valid_o <= 1'b0;
      load_pc_o <= 1'b0;
      pop_valid_o <= 1'b0;
      // A blocking instruction holds off vectoring past its following instruction.
      if (instr_last_i)
        block_next_r <= instr_blocking_i;
      if (return_from_isr_i)
      begin
        pop_r <= ctrl_r[`IV_CTRL_FRAME_BIT] ? 3'd4 : 3'd2;
        if (active_r[1])
          active_r[1] <= 1'b0;
        else
          active_r[0] <= 1'b0;
      end
      else if (subroutine_return_i)
        pop_r <= 3'd2;
      else if (pop_r != 3'h0)
      begin
        pop_r <= pop_r - 3'h1;
        pop_valid_o <= 1'b1;
      end
      case (state_r)
        ST_IDLE:
          if (can_vector)
          begin
            sel_hi_r <= any_hi;
            sel_r <= any_hi ? pick_hi : pick_lo;
            pc_save_r <= pc_i;
            psw_save_r <= extended_status_word_i;
            state_r <= ST_WAIT;
            vec_break_o <= 1'b1;
            wait_r <= 4'h0;
          end
        ST_WAIT:
          if (wait_r == 4'h0 && bytes_r == 3'h0)
          begin
            wait_r <= wait_states;
            bytes_r <= ctrl_r[`IV_CTRL_FRAME_BIT] ? 3'd4 : 3'd2;
            state_r <= ST_PUSH;
          end
        ST_PUSH:
        begin
          wait_r <= wait_r - 4'h1;
          if (bytes_r != 3'h0)
          begin
            bytes_r <= bytes_r - 3'h1;
            push_valid_o <= 1'b1;
            // The low counter byte always goes first, whatever the frame size.
            case (bytes_r)
              3'd4: push_data_o <= pc_save_r[7:0];
              3'd3: push_data_o <= pc_save_r[15:8];
              3'd2: push_data_o <= ctrl_r[`IV_CTRL_FRAME_BIT] ? pc_save_r[23:16] : pc_save_r[7:0];
              default: push_data_o <= ctrl_r[`IV_CTRL_FRAME_BIT] ? psw_save_r : pc_save_r[15:8];
            endcase
          end
          if (wait_r == 4'h1)
            state_r <= ST_LOAD;
        end
        ST_LOAD:
        begin
          load_pc_o <= 1'b1;
          load_addr_o <= vec_base_r + {18'h00000, sel_r, 3'h0};
          if (sel_hi_r)
            active_r[1] <= 1'b1;
          else
            active_r[0] <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Register file; sticky status sets win over write-one-to-clear.
  always @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      enable_r <= 8'h00;
      prio_r <= 8'h00;
      ctrl_r <= 3'h0;
      vec_base_r <= `IV_VEC_BASE_RST;
      status_r <= 3'h0;
      mask_r <= 3'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      pready <= apb_rd || (psel && !penable && pwrite);
      pslverr <= 1'b0;
      status_r <= (status_r & ~((apb_wr && paddr == `IV_OFF_STATUS) ? pwdata[2:0] : 3'h0)) | ev;
      irq_o <= |(status_r & mask_r);
      if (apb_wr)
        case (paddr)
          `IV_OFF_CTRL: ctrl_r <= pwdata[2:0];
          `IV_OFF_MASK: mask_r <= pwdata[2:0];
          `IV_OFF_ENABLE: enable_r <= pwdata[7:0];
          `IV_OFF_PRIO: prio_r <= pwdata[7:0];
          `IV_OFF_VECBASE: vec_base_r <= pwdata[23:0];
          default: ;
        endcase
      if (psel && !penable)
        case (paddr)
          `IV_OFF_CTRL: prdata <= {29'h0, ctrl_r};
          `IV_OFF_STATUS: prdata <= {29'h0, status_r};
          `IV_OFF_MASK: prdata <= {29'h0, mask_r};
          `IV_OFF_ENABLE: prdata <= {24'h0, enable_r};
          `IV_OFF_PRIO: prdata <= {24'h0, prio_r};
          `IV_OFF_VECBASE: prdata <= {8'h0, vec_base_r};
          `IV_OFF_ACTIVE: prdata <= {22'h0, pend_r, active_r};
          `IV_OFF_LASTVEC: prdata <= {8'h0, load_addr_o};
          default:
          begin
            // Flagged in setup so the error stands beside pready in the access cycle.
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
    end
  end
endmodule // irq_vector_ctrl

// ===== verilog/irq_vector_defines.vh
// Offsets, field positions, reset values and timing counts of the interrupt vectoring block.
`ifndef IRQ_VECTOR_DEFINES_VH
`define IRQ_VECTOR_DEFINES_VH
`define IV_NUM_SRC 8
`define IV_STATES_PER_POLL 4
`define IV_BASE_LATENCY 16
`define IV_CTX_SWITCH_STATES 11
`define IV_ADD_EXT_PIN 1
`define IV_ADD_EXT_EXEC 2
`define IV_ADD_EXT_STACK 4
`define IV_VEC_SPACING 24'h000008
`define IV_VEC_BASE_RST 24'hFF0003
`define IV_OFF_CTRL 12'h000
`define IV_OFF_STATUS 12'h004
`define IV_OFF_MASK 12'h008
`define IV_OFF_ENABLE 12'h00C
`define IV_OFF_PRIO 12'h010
`define IV_OFF_VECBASE 12'h014
`define IV_OFF_ACTIVE 12'h018
`define IV_OFF_LASTVEC 12'h01C
`define IV_CTRL_FRAME_BIT 0
`define IV_CTRL_EXT_EXEC_BIT 1
`define IV_CTRL_EXT_STACK_BIT 2
`define IV_ST_VECTOR_BIT 0
`define IV_ST_RETURN_BIT 1
`define IV_ST_DROP_BIT 2
`endif
